// *** core/sepc_pkg.sv ***
package sepc_pkg;

  // system clock, kHz, so that millisecond products stay small
  localparam int unsigned CLK_KHZ       = 200_000;

  // self-timed program cycle limits, ms
  localparam int unsigned T_WC_LV_MS    = 5;
  localparam int unsigned T_WC_HV_MS    = 2;
  localparam int unsigned T_ERASE_ALL_MS = 6;
  localparam int unsigned T_WRITE_ALL_MS = 15;

  // longest times, rounded down to whole cycles
  localparam int unsigned CYC_WC_LV     = T_WC_LV_MS * CLK_KHZ;
  localparam int unsigned CYC_WC_HV     = T_WC_HV_MS * CLK_KHZ;
  localparam int unsigned CYC_ERASE_ALL = T_ERASE_ALL_MS * CLK_KHZ;
  localparam int unsigned CYC_WRITE_ALL = T_WRITE_ALL_MS * CLK_KHZ;

  // frame fields per organisation
  localparam logic [4:0]  ABITS_X16     = 5'h0A;
  localparam logic [4:0]  ABITS_X8      = 5'h0B;
  localparam logic [4:0]  DBITS_X16     = 5'h10;
  localparam logic [4:0]  DBITS_X8      = 5'h08;
  localparam int unsigned WORD_AW       = 10;
  localparam int unsigned WORDS         = 1024;
  localparam int unsigned BUF_DEPTH     = 2;

  // opcodes
  localparam logic [1:0]  OPC_READ      = 2'h2;
  localparam logic [1:0]  OPC_WRITE     = 2'h1;
  localparam logic [1:0]  OPC_ERASE     = 2'h3;
  localparam logic [1:0]  OPC_SPECIAL   = 2'h0;

  // special sub-codes in the two address MSBs
  localparam logic [1:0]  SUB_ENABLE    = 2'h3;
  localparam logic [1:0]  SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0]  SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0]  SUB_DISABLE   = 2'h0;

  // reset values
  localparam logic        RST_ENABLED   = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_DONE
  } sepc_state_e;

  typedef enum logic [1:0] {
    PRG_ERASE, PRG_WRITE, PRG_ERASE_ALL, PRG_WRITE_ALL
  } sepc_prog_e;

endpackage

// *** core/sepc_core.sv ***
`timescale 1ns/10ps
// Functional notes
// - word_size_select high gives 16-bit words, low gives 8-bit words.
// - serial_in bits are sampled on each rising serial clock edge.
// - output is driven only for read data or ready/busy status.
// - status output is low while programming, high once ready.
// - output released when select falls.
// - start bit is first rising edge with select and serial_in high.
// - no operation of any kind happens before a start bit.
// - standby is left as soon as select goes high.
// - an instruction runs only once all its bits arrived, else abandoned.
// - 16-bit frames: start, opcode, ten address, sixteen data; 29 or 13.
// - 8-bit frames: eleven address, eight data; 22 or 14; special subcodes.
// - single erase or write finishes within 5 ms, or 2 ms at 5 V.
// - erase-all finishes within 6 ms, write-all within 15 ms.
// - a dummy zero precedes read data, sent most significant bit first.
// - programming disabled after reset until enable instruction runs.
// - write and write-all start programming at the last data bit edge.
// - select low resets control logic; running program cycle completes.
module sepc_core #(
  parameter int unsigned P_WC_LV_CYC     = sepc_pkg::CYC_WC_LV,
  parameter int unsigned P_WC_HV_CYC     = sepc_pkg::CYC_WC_HV,
  parameter int unsigned P_ERASE_ALL_CYC = sepc_pkg::CYC_ERASE_ALL,
  parameter int unsigned P_WRITE_ALL_CYC = sepc_pkg::CYC_WRITE_ALL,
  parameter bit          P_FIVE_VOLT     = 1'b0,
  parameter int unsigned P_BUF_DEPTH     = sepc_pkg::BUF_DEPTH
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_select,
  input  wire logic i_serial_clk,
  input  wire logic i_serial_in,
  input  wire logic i_word_size_select,
  input  wire logic i_program_enable_pin,
  output logic      o_serial_out,
  output logic      o_serial_out_oe
);

  localparam int unsigned WC_CYC = P_FIVE_VOLT ? P_WC_HV_CYC : P_WC_LV_CYC;
  localparam int unsigned PW     = (P_BUF_DEPTH > 1) ? $clog2(P_BUF_DEPTH) : 1;

  logic [4:0]            meta_q;
  logic [4:0]            sync_q;
  logic                  sclk_d_q;
  logic                  cs_s;
  logic                  din_s;
  logic                  org_s;
  logic                  pe_s;
  logic                  rise;
  sepc_pkg::sepc_state_e state_q;
  logic [4:0]            cnt_q;
  logic [1:0]            opc_q;
  logic [10:0]           addr_q;
  logic [15:0]           data_q;
  logic                  x16_q;
  logic                  enabled_q;
  logic                  busy_q;
  logic                  stat_pend_q;
  logic [31:0]           prog_cnt_q;
  sepc_pkg::sepc_prog_e  prog_op_q;
  logic [10:0]           prog_addr_q;
  logic [15:0]           prog_data_q;
  logic                  prog_x16_q;
  logic [15:0]           mem [sepc_pkg::WORDS];
  logic [15:0]           buf_q [P_BUF_DEPTH];
  logic [PW-1:0]         wptr_q;
  logic [PW-1:0]         rptr_q;
  logic [PW:0]           fill_q;
  logic [10:0]           rd_addr_q;
  logic                  rd_active_q;
  logic [15:0]           sh_out_q;
  logic [4:0]            left_q;

  // metastability guard on every pin but i_clk and i_resetn, link clock included; stage one feeds only stage two.
  // data and select share the clock's lag, so they are settled at every detected edge
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q   <= 5'h00;
      sync_q   <= 5'h00;
      sclk_d_q <= 1'b0; // idle level of the link clock, so no false edge after reset
    end else begin
      meta_q   <= {i_serial_clk, i_program_enable_pin, i_word_size_select, i_serial_in, i_select};
      sync_q   <= meta_q;
      sclk_d_q <= sync_q[4];
    end
  end

  assign cs_s  = sync_q[0];
  assign din_s = sync_q[1];
  assign org_s = sync_q[2];
  assign pe_s  = sync_q[3];
  assign rise  = sync_q[4] && !sclk_d_q && cs_s;

  // frame decode helpers
  logic [4:0]  abits;
  logic [4:0]  dbits;
  logic [10:0] addr_nx;
  logic [15:0] data_nx;
  logic [1:0]  sub;
  logic        start_hit;
  logic        last_addr;
  logic        last_data;
  logic        may_prog;
  logic        read_go;
  logic        prog_go;
  assign abits     = x16_q ? sepc_pkg::ABITS_X16 : sepc_pkg::ABITS_X8;
  assign dbits     = x16_q ? sepc_pkg::DBITS_X16 : sepc_pkg::DBITS_X8;
  assign addr_nx   = {addr_q[9:0], din_s};
  assign data_nx   = {data_q[14:0], din_s};
  assign sub       = x16_q ? addr_nx[9:8] : addr_nx[10:9];
  assign start_hit = rise && din_s && state_q == sepc_pkg::ST_IDLE;
  assign last_addr = rise && state_q == sepc_pkg::ST_ADDR && cnt_q == abits - 5'h01;
  assign last_data = rise && state_q == sepc_pkg::ST_DATA && cnt_q == dbits - 5'h01;
  assign may_prog  = enabled_q && pe_s && !busy_q;
  assign read_go   = last_addr && opc_q == sepc_pkg::OPC_READ;
  // work starts only at the final bit of a full frame
  assign prog_go   = may_prog && ((last_addr && opc_q == sepc_pkg::OPC_ERASE)
                   || (last_addr && opc_q == sepc_pkg::OPC_SPECIAL
                       && sub == sepc_pkg::SUB_ERASE_ALL)
                   || (last_data && opc_q != sepc_pkg::OPC_READ));

  // frame sequencer; select low throws away any partial frame
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !cs_s) begin
      state_q <= sepc_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
    end else if (rise) begin
      case (state_q)
        sepc_pkg::ST_IDLE: if (din_s) begin
          state_q <= sepc_pkg::ST_OPC;
          cnt_q   <= 5'h00;
        end
        sepc_pkg::ST_OPC: begin
          cnt_q <= (cnt_q == 5'h01) ? 5'h00 : cnt_q + 5'h01;
          if (cnt_q == 5'h01) state_q <= sepc_pkg::ST_ADDR;
        end
        sepc_pkg::ST_ADDR: begin
          cnt_q <= last_addr ? 5'h00 : cnt_q + 5'h01;
          if (last_addr) begin
            if (opc_q == sepc_pkg::OPC_READ)
              state_q <= sepc_pkg::ST_READ;
            else if (opc_q == sepc_pkg::OPC_WRITE
                     || (opc_q == sepc_pkg::OPC_SPECIAL && sub == sepc_pkg::SUB_WRITE_ALL))
              state_q <= sepc_pkg::ST_DATA;
            else
              state_q <= sepc_pkg::ST_DONE;
          end
        end
        sepc_pkg::ST_DATA: begin
          cnt_q <= cnt_q + 5'h01;
          if (last_data) state_q <= sepc_pkg::ST_DONE;
        end
        sepc_pkg::ST_READ: state_q <= sepc_pkg::ST_READ;
        sepc_pkg::ST_DONE: state_q <= sepc_pkg::ST_DONE;
        default: state_q <= sepc_pkg::ST_IDLE;
      endcase
    end
  end

  // field shifters; organisation is frozen at the start bit
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      opc_q  <= 2'h0;
      addr_q <= 11'h000;
      data_q <= 16'h0000;
      x16_q  <= 1'b0;
    end else if (rise) begin
      if (start_hit) x16_q <= org_s;
      if (state_q == sepc_pkg::ST_OPC)  opc_q  <= {opc_q[0], din_s};
      if (state_q == sepc_pkg::ST_ADDR) addr_q <= addr_nx;
      if (state_q == sepc_pkg::ST_DATA) data_q <= data_nx;
    end
  end

  // write protection latch: survives select low, cleared by reset or the disable instruction
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      enabled_q <= sepc_pkg::RST_ENABLED;
    end else if (last_addr && opc_q == sepc_pkg::OPC_SPECIAL) begin
      if (sub == sepc_pkg::SUB_ENABLE)  enabled_q <= 1'b1;
      if (sub == sepc_pkg::SUB_DISABLE) enabled_q <= 1'b0;
    end
  end

  // self-timed program engine; keeps running with select low
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      busy_q      <= 1'b0;
      prog_cnt_q  <= 32'h0000_0000;
      prog_op_q   <= sepc_pkg::PRG_ERASE;
      prog_addr_q <= 11'h000;
      prog_data_q <= 16'h0000;
      prog_x16_q  <= 1'b0;
    end else if (prog_go) begin
      busy_q      <= 1'b1;
      prog_addr_q <= last_data ? addr_q : addr_nx;
      prog_data_q <= data_nx;
      prog_x16_q  <= x16_q;
      if (opc_q == sepc_pkg::OPC_ERASE) begin
        prog_op_q  <= sepc_pkg::PRG_ERASE;
        prog_cnt_q <= 32'(WC_CYC - 1);
      end else if (opc_q == sepc_pkg::OPC_WRITE) begin
        prog_op_q  <= sepc_pkg::PRG_WRITE;
        prog_cnt_q <= 32'(WC_CYC - 1);
      end else if (last_data) begin
        prog_op_q  <= sepc_pkg::PRG_WRITE_ALL;
        prog_cnt_q <= 32'(P_WRITE_ALL_CYC - 1);
      end else begin
        prog_op_q  <= sepc_pkg::PRG_ERASE_ALL;
        prog_cnt_q <= 32'(P_ERASE_ALL_CYC - 1);
      end
    end else if (busy_q) begin
      if (prog_cnt_q == 32'h0000_0000) busy_q <= 1'b0;
      else prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
    end
  end

  // array commit in the last cycle of the program time
  always_ff @(posedge i_clk) begin
    if (busy_q && prog_cnt_q == 32'h0000_0000) begin
      case (prog_op_q)
        sepc_pkg::PRG_ERASE, sepc_pkg::PRG_WRITE: begin
          if (prog_x16_q)
            mem[prog_addr_q[9:0]] <= (prog_op_q == sepc_pkg::PRG_ERASE) ? 16'hFFFF : prog_data_q;
          else if (prog_addr_q[0])
            mem[prog_addr_q[10:1]][15:8] <= (prog_op_q == sepc_pkg::PRG_ERASE)
                                            ? 8'hFF : prog_data_q[7:0];
          else
            mem[prog_addr_q[10:1]][7:0] <= (prog_op_q == sepc_pkg::PRG_ERASE)
                                           ? 8'hFF : prog_data_q[7:0];
        end
        sepc_pkg::PRG_ERASE_ALL:
          for (int i = 0; i < sepc_pkg::WORDS; i++) mem[i] <= 16'hFFFF;
        sepc_pkg::PRG_WRITE_ALL:
          for (int i = 0; i < sepc_pkg::WORDS; i++)
            mem[i] <= prog_x16_q ? prog_data_q : {prog_data_q[7:0], prog_data_q[7:0]};
        default: ;
      endcase
    end
  end

  // status stays pending until the next start bit; a new cycle beats the clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn)      stat_pend_q <= 1'b0;
    else if (prog_go)   stat_pend_q <= 1'b1;
    else if (start_hit) stat_pend_q <= 1'b0;
  end

  // read prefetch into a small buffer; the output shifter drains it,
  // so sequential reads run on without gaps
  logic        buf_push;
  logic        buf_pop;
  logic        buf_full;
  logic        buf_empty;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  assign buf_full  = fill_q == (PW + 1)'(P_BUF_DEPTH);
  assign buf_empty = fill_q == '0;
  assign buf_push  = rd_active_q && !buf_full;
  assign buf_pop   = rise && state_q == sepc_pkg::ST_READ && left_q == 5'h00 && !buf_empty;
  assign rd_word   = mem[x16_q ? rd_addr_q[9:0] : rd_addr_q[10:1]];
  assign rd_byte   = rd_addr_q[0] ? rd_word[15:8] : rd_word[7:0];

  always_ff @(posedge i_clk) begin
    if (!i_resetn || read_go || state_q != sepc_pkg::ST_READ) begin
      wptr_q      <= '0;
      rptr_q      <= '0;
      fill_q      <= '0;
      rd_active_q <= read_go;
      rd_addr_q   <= read_go ? addr_nx : 11'h000;
    end else begin
      if (buf_push) begin
        buf_q[wptr_q] <= x16_q ? rd_word : {rd_byte, 8'h00};
        wptr_q        <= (wptr_q == PW'(P_BUF_DEPTH - 1)) ? '0 : wptr_q + PW'(1);
        rd_addr_q     <= x16_q ? {1'b0, rd_addr_q[9:0] + 10'h001} : rd_addr_q + 11'h001;
      end
      if (buf_pop) rptr_q <= (rptr_q == PW'(P_BUF_DEPTH - 1)) ? '0 : rptr_q + PW'(1);
      fill_q <= fill_q + (PW + 1)'(buf_push) - (PW + 1)'(buf_pop);
    end
  end

  // output shifter, most significant bit first
  always_ff @(posedge i_clk) begin
    if (!i_resetn || read_go) begin
      sh_out_q <= 16'h0000;
      left_q   <= 5'h00;
    end else if (rise && state_q == sepc_pkg::ST_READ) begin
      if (left_q == 5'h00) begin
        sh_out_q <= buf_empty ? 16'h0000 : {buf_q[rptr_q][14:0], 1'b0};
        left_q   <= dbits - 5'h01;
      end else begin
        sh_out_q <= {sh_out_q[14:0], 1'b0};
        left_q   <= left_q - 5'h01;
      end
    end
  end

  // serial output pin and its enable
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !cs_s) begin
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else if (read_go) begin
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b1;
    end else if (state_q == sepc_pkg::ST_READ) begin
      o_serial_out_oe <= 1'b1;
      if (rise)
        o_serial_out <= (left_q == 5'h00) ? (!buf_empty && buf_q[rptr_q][15]) : sh_out_q[15];
    end else if (state_q == sepc_pkg::ST_IDLE && stat_pend_q && !start_hit) begin
      o_serial_out    <= !busy_q;
      o_serial_out_oe <= 1'b1;
    end else begin
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end
  end

  a_oe_off_deselect: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !cs_s |=> !o_serial_out_oe) else $error("output driven while deselected");
  a_status_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cs_s && stat_pend_q && state_q == sepc_pkg::ST_IDLE && !start_hit
    |=> o_serial_out_oe && o_serial_out == !$past(busy_q)) else $error("bad status level");
  a_no_op_prestart: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_q == sepc_pkg::ST_IDLE |=> $stable(enabled_q) && !$rose(busy_q))
    else $error("operation before start bit");
  a_start_detect: assert property (@(posedge i_clk) disable iff (!i_resetn)
    start_hit |=> state_q == sepc_pkg::ST_OPC) else $error("start bit missed");
  a_prog_enabled: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(busy_q) |-> $past(enabled_q) && $past(pe_s)) else $error("program while disabled");
  a_single_time: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(busy_q) && (prog_op_q == sepc_pkg::PRG_ERASE || prog_op_q == sepc_pkg::PRG_WRITE)
    |-> prog_cnt_q == 32'(WC_CYC - 1)) else $error("wrong single program time");
  a_bulk_time: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(busy_q) && prog_op_q == sepc_pkg::PRG_WRITE_ALL
    |-> prog_cnt_q == 32'(P_WRITE_ALL_CYC - 1)) else $error("wrong write-all time");
  a_busy_survives: assert property (@(posedge i_clk) disable iff (!i_resetn)
    busy_q && prog_cnt_q != 32'h0000_0000 && !cs_s |=> busy_q && state_q == sepc_pkg::ST_IDLE)
    else $error("program cut short or control not reset");
  a_read_dummy: assert property (@(posedge i_clk) disable iff (!i_resetn)
    read_go |=> o_serial_out_oe && !o_serial_out) else $error("no dummy zero");
  a_done_ignores: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_q == sepc_pkg::ST_DONE && cs_s |=> state_q == sepc_pkg::ST_DONE)
    else $error("clock edge acted on after instruction");
  a_write_starts: assert property (@(posedge i_clk) disable iff (!i_resetn)
    last_data && may_prog |=> busy_q && stat_pend_q) else $error("write did not start");

endmodule // sepc_core

// *** test/sepc_master.sv ***
`timescale 1ns/10ps
// far-side serial master: drives select, link clock and serial input
module sepc_master (
  input  wire logic i_clk,
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe,
  output logic      o_select,
  output logic      o_serial_clk,
  output logic      o_serial_in
);
  bit own; // high while the master owns serial_in

  initial begin
    o_select     = 1'b0;
    o_serial_clk = 1'b0;
    o_serial_in  = 1'b0;
    own          = 1'b0;
  end

  // a released data line wiggles, so a stale level never passes for a bit
  always @(posedge i_clk) begin
    if (!own) begin
      o_serial_in <= ~o_serial_in;
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // link clock and data are parked low as select rises, so no false start
  task automatic select_up();
    own = 1'b1;
    @(posedge i_clk); // the wiggle stops first, so serial_in has one driver per edge
    o_serial_in <= 1'b0;
    o_select <= 1'b1;
    wait_clk(10);
  endtask

  // callers keep the whole low time at 60 cycles or more
  task automatic select_down(input int gap);
    o_select <= 1'b0;
    own = 1'b0;
    wait_clk(gap);
  endtask

  // one bit per link clock, stretched by slow; data out read late in the high half
  task automatic shift(input logic [63:0] v, input int n, input int slow,
                       output logic [63:0] rx, output logic [63:0] rx_oe);
    rx = '0;
    rx_oe = '0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in <= v[i];
      wait_clk(12 + slow);
      o_serial_clk <= 1'b1;
      wait_clk(13);
      rx = {rx[62:0], i_serial_out_oe ? i_serial_out : !i_serial_out}; // released pin reads inverted
      rx_oe = {rx_oe[62:0], i_serial_out_oe};
      o_serial_clk <= 1'b0;
    end
  endtask
endmodule // sepc_master

// *** test/sepc_core_tb.sv ***
`timescale 1ns/10ps
module sepc_core_tb;
  // shortened program times keep the run short
  localparam int unsigned WC  = 2000;
  localparam int unsigned EA  = 2400;
  localparam int unsigned WA  = 3000;
  localparam int          LIM = 80000;

  logic        i_clk;
  logic        i_resetn;
  logic        wss;
  logic        pe;
  logic        sel;
  logic        sclk;
  logic        sdi;
  logic        dout;
  logic        dout_oe;
  logic [63:0] rx;
  logic [63:0] rx_oe;
  logic [31:0] seed;
  int          fails;
  int          n_tests;
  int          cyc = 0;
  int          mem[1024];
  bit          en;
  int          a;
  int          d;

  sepc_core #(
    .P_WC_LV_CYC(WC), .P_ERASE_ALL_CYC(EA), .P_WRITE_ALL_CYC(WA)
  ) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_select(sel), .i_serial_clk(sclk),
    .i_serial_in(sdi), .i_word_size_select(wss), .i_program_enable_pin(pe),
    .o_serial_out(dout), .o_serial_out_oe(dout_oe)
  );

  sepc_master u_mst (
    .i_clk(i_clk), .i_serial_out(dout), .i_serial_out_oe(dout_oe),
    .o_select(sel), .o_serial_clk(sclk), .o_serial_in(sdi)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int dw();
    return wss ? 16 : 8;
  endfunction

  // byte mode: bit 0 of the address picks the high or low half of a word
  function automatic logic [15:0] exp_rd(input int ad);
    if (wss) return 16'(mem[ad]);
    return (ad & 1) ? 16'(mem[ad >> 1] >> 8) : 16'(mem[ad >> 1] & 'hFF);
  endfunction

  task automatic mwr(input int ad, input int dv);
    if (!(en && pe)) return;
    if (wss) mem[ad] = dv & 'hFFFF;
    else if (ad & 1) mem[ad >> 1] = (mem[ad >> 1] & 'hFF) | ((dv & 'hFF) << 8);
    else mem[ad >> 1] = (mem[ad >> 1] & 'hFF00) | (dv & 'hFF);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk_data({15'h0, got}, {15'h0, exp});
  endtask

  task automatic mode(input bit w, input bit p);
    @(posedge i_clk);
    wss <= w;
    pe  <= p;
    @(posedge i_clk);
  endtask

  // frame: zeros, start bit, opcode, address, then tl data or read clocks
  task automatic cmd(input logic [1:0] op, input int ad, input int dv, input int tl,
                     input int lead);
    logic [63:0] v;
    int          aw;
    aw = wss ? 10 : 11;
    v = {61'h0, 1'b1, op};
    v = (v << aw) | 64'(ad);
    v = (v << tl) | 64'(dv);
    u_mst.select_up();
    u_mst.shift(v, lead + 3 + aw + tl, int'(rnd() % 8), rx, rx_oe);
    u_mst.select_down(7);
    chk_pin(dout_oe, 1'b0);
    u_mst.wait_clk(53);
  endtask

  task automatic spc(input logic [1:0] sub, input int dv, input int tl);
    cmd(sepc_pkg::OPC_SPECIAL, int'(sub) << (wss ? 8 : 9), dv, tl, 0);
  endtask

  // status poll: select up with no start bit, wait for ready, clear with a start
  task automatic poll(input bit busy, input int lim);
    int cnt;
    cnt = 0;
    u_mst.select_up();
    chk_pin(dout_oe, busy);
    if (busy) begin
      chk_pin(dout, 1'b0);
      while (dout !== 1'b1 && cnt < lim) begin
        @(posedge i_clk);
        cnt++;
      end
      chk_pin(dout, 1'b1);
      u_mst.shift(64'h1, 1, 0, rx, rx_oe);
      chk_pin(dout_oe, 1'b0);
    end
    u_mst.select_down(60);
  endtask

  task automatic wr(input int ad, input int dv);
    cmd(sepc_pkg::OPC_WRITE, ad, dv, dw(), 0);
    mwr(ad, dv);
    poll(en && pe, WC);
  endtask

  // two locations in one frame after the dummy zero
  task automatic rd(input int ad);
    logic [15:0] m;
    m = wss ? 16'hFFFF : 16'h00FF;
    cmd(sepc_pkg::OPC_READ, ad, 0, 2 * dw(), 2);
    chk_pin(rx_oe[2 * dw() + 1], 1'b0);
    chk_pin(rx[2 * dw()], 1'b0);
    chk_data(16'(rx_oe >> dw()) & m, m);
    chk_data(16'(rx_oe) & m, m);
    chk_data(16'(rx >> dw()) & m, exp_rd(ad));
    chk_data(16'(rx) & m, exp_rd(ad + 1));
  endtask

  initial begin
    i_resetn = 1'b0;
    wss      = 1'b1;
    pe       = 1'b1;
    seed     = 32'h5AC865CE;
    fails    = 0;
    n_tests  = 0;
    en       = 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk_pin(dout_oe, 1'b0);
    u_mst.select_up();
    u_mst.shift(64'h0, 20, 0, rx, rx_oe);
    chk_data(16'(rx_oe), 16'h0000);
    u_mst.select_down(60);
    d = int'(rnd() & 32'hFFFF);
    spc(sepc_pkg::SUB_WRITE_ALL, d, 16);
    poll(1'b0, 0);
    spc(sepc_pkg::SUB_ENABLE, 0, 0);
    en = 1'b1;
    spc(sepc_pkg::SUB_WRITE_ALL, d, 16);
    foreach (mem[i]) mem[i] = d;
    poll(1'b1, WA);
    $display("test protect and write-all done");
    for (int m = 1; m >= 0; m--) begin
      mode(m[0], 1'b1);
      spc(sepc_pkg::SUB_ENABLE, 0, 0);
      en = 1'b1;
      repeat (2) begin
        a = int'(rnd() % (wss ? 1023 : 2047));
        d = int'(rnd()) & ((1 << dw()) - 1);
        wr(a, d);
        rd(a);
      end
      cmd(sepc_pkg::OPC_ERASE, a, 0, 0, 0);
      mwr(a, 'hFFFF);
      poll(1'b1, WC);
      rd(a);
      cmd(sepc_pkg::OPC_WRITE, a, d >> 1, dw() - 1, 0);
      poll(1'b0, 0);
      rd(a);
      spc(sepc_pkg::SUB_DISABLE, 0, 0);
      en = 1'b0;
      wr(a, 0);
      rd(a);
      $display("test word size %0d done", m);
    end
    spc(sepc_pkg::SUB_ENABLE, 0, 0);
    en = 1'b1;
    mode(1'b1, 1'b0);
    a = int'(rnd() % 1023);
    wr(a, 'h5A5A);
    rd(a);
    mode(1'b1, 1'b1);
    spc(sepc_pkg::SUB_ERASE_ALL, 0, 0);
    foreach (mem[i]) mem[i] = 'hFFFF;
    poll(1'b1, EA);
    rd(a);
    u_mst.select_up();
    u_mst.shift({38'h0, 13'h1000, 13'h1300}, 26, 0, rx, rx_oe);
    u_mst.select_down(60);
    en = 1'b0;
    wr(a, 'h1234);
    rd(a);
    $display("test refusals done");
    report_and_stop();
  end

  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
endmodule // sepc_core_tb
